// ### rtl/afe_device.sv
// Digital side of the front end: serial register port and output path.
// Assumes the controller drives the serial pins and the sample sync.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module afe_device import afe_pkg::*; #(
  parameter int PIPE_DEPTH = 3,
  parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary value.
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  afe_if.device link,
  input wire logic signed [15:0] sample_diff,
  output logic [15:0] last_code
);
  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic [3:0] pins;
  logic sck_q, sen_q, sample_sync_pulse_q;
  logic sck_rise, sck_fall, sen_rise, sample_sync_pulse_rise;

  afe_sync #(.WIDTH(4)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({link.sck, link.sdi, link.serial_enable_strobe,
               link.sample_sync_pulse}),
    .sync_out(pins)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sck_q <= 1'b0;
      sen_q <= 1'b0;
      sample_sync_pulse_q <= 1'b0;
    end else if (clk_en) begin
      sck_q <= pins[3];
      sen_q <= pins[1];
      sample_sync_pulse_q <= pins[0];
    end
  end

  assign sck_rise = clk_en && pins[3] && !sck_q;
  assign sck_fall = clk_en && !pins[3] && sck_q;
  assign sen_rise = clk_en && pins[1] && !sen_q;
  assign sample_sync_pulse_rise = clk_en && pins[0] && !sample_sync_pulse_q;

  // ****************************************************************
  // Serial frame capture
  // ****************************************************************
  logic [`AFE_FRAME_BITS-1:0] shift_in;
  logic [5:0] frame_addr;
  logic [7:0] frame_data;
  logic do_write, do_read, do_swrst;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_in <= '0;
    end else if (sck_rise) begin
      shift_in <= {shift_in[`AFE_FRAME_BITS-2:0], pins[2]};
    end
  end

  assign frame_addr = shift_in[`AFE_FRAME_BITS-1:8];
  assign frame_data = shift_in[7:0];
  assign do_write = sen_rise && !frame_addr[`AFE_READ_BIT];
  assign do_read = sen_rise && frame_addr[`AFE_READ_BIT];
  assign do_swrst = do_write && frame_addr == `AFE_ADDR_SWRST;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] setup1, setup2, setup3, setup4, setup5;
  logic [7:0] offset_code_red, offset_code_green, offset_code_blue;
  logic [7:0] gain_code_red, gain_code_green, gain_code_blue;

  always_ff @(posedge core_clk) begin
    if (sys_rst || do_swrst) begin
      setup1 <= `AFE_DEF_SETUP1;
      setup2 <= `AFE_DEF_SETUP2;
      setup3 <= `AFE_DEF_SETUP3;
      setup4 <= `AFE_DEF_SETUP4;
      setup5 <= `AFE_DEF_SETUP5;
      offset_code_red <= `AFE_DEF_OFFSET;
      offset_code_green <= `AFE_DEF_OFFSET;
      offset_code_blue <= `AFE_DEF_OFFSET;
      gain_code_red <= `AFE_DEF_GAIN;
      gain_code_green <= `AFE_DEF_GAIN;
      gain_code_blue <= `AFE_DEF_GAIN;
    end else if (do_write) begin
      if (frame_addr == `AFE_ADDR_SETUP1) begin
        setup1 <= frame_data;
      end else if (frame_addr == `AFE_ADDR_SETUP2) begin
        setup2 <= frame_data;
      end else if (frame_addr == `AFE_ADDR_SETUP3) begin
        setup3 <= frame_data;
      end else if (frame_addr == `AFE_ADDR_SETUP4) begin
        setup4 <= frame_data;
      end else if (frame_addr == `AFE_ADDR_SETUP5) begin
        setup5 <= frame_data;
      end else if (frame_addr == `AFE_ADDR_OFF_RED) begin
        offset_code_red <= frame_data;
      end else if (frame_addr == `AFE_ADDR_OFF_GREEN) begin
        offset_code_green <= frame_data;
      end else if (frame_addr == `AFE_ADDR_OFF_BLUE) begin
        offset_code_blue <= frame_data;
      end else if (frame_addr == `AFE_ADDR_OFF_ALL) begin
        offset_code_red <= frame_data;
        offset_code_green <= frame_data;
        offset_code_blue <= frame_data;
      end else if (frame_addr == `AFE_ADDR_GAIN_RED) begin
        gain_code_red <= frame_data;
      end else if (frame_addr == `AFE_ADDR_GAIN_GREEN) begin
        gain_code_green <= frame_data;
      end else if (frame_addr == `AFE_ADDR_GAIN_BLUE) begin
        gain_code_blue <= frame_data;
      end else if (frame_addr == `AFE_ADDR_GAIN_ALL) begin
        gain_code_red <= frame_data;
        gain_code_green <= frame_data;
        gain_code_blue <= frame_data;
      end
    end
  end

  // Write-only and unmapped addresses read back as zero.
  function automatic logic [7:0] read_reg(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `AFE_ADDR_SETUP1) begin
      v = setup1;
    end else if (a == `AFE_ADDR_SETUP2) begin
      v = setup2;
    end else if (a == `AFE_ADDR_SETUP3) begin
      v = setup3;
    end else if (a == `AFE_ADDR_SETUP4) begin
      v = setup4;
    end else if (a == `AFE_ADDR_REVISION) begin
      v = REVISION_CODE;
    end else if (a == `AFE_ADDR_SETUP5) begin
      v = setup5;
    end else if (a == `AFE_ADDR_OFF_RED) begin
      v = offset_code_red;
    end else if (a == `AFE_ADDR_OFF_GREEN) begin
      v = offset_code_green;
    end else if (a == `AFE_ADDR_OFF_BLUE) begin
      v = offset_code_blue;
    end else if (a == `AFE_ADDR_GAIN_RED) begin
      v = gain_code_red;
    end else if (a == `AFE_ADDR_GAIN_GREEN) begin
      v = gain_code_green;
    end else if (a == `AFE_ADDR_GAIN_BLUE) begin
      v = gain_code_blue;
    end
    return v;
  endfunction

  // ****************************************************************
  // Read-back shifter
  // ****************************************************************
  logic [7:0] rd_shift;
  logic [2:0] rd_cnt;
  logic rd_active;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_shift <= 8'h00;
      rd_cnt <= 3'h0;
      rd_active <= 1'b0;
    end else if (do_read) begin
      rd_shift <= read_reg(frame_addr & ~6'h10);
      rd_cnt <= 3'h0;
      rd_active <= 1'b1;
    end else if (sck_fall && rd_active) begin
      rd_shift <= {rd_shift[6:0], 1'b0};
      rd_cnt <= rd_cnt + 3'h1;
      if (rd_cnt == 3'h7) begin
        rd_active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Conversion path
  // ****************************************************************
  afe_colour_e colour_select;
  logic [1:0] adc_range_select, output_latency;
  logic output_invert;
  logic [7:0] sel_offset, sel_gain;
  logic signed [31:0] v2, v3, d1;
  logic [15:0] next_code;

  assign colour_select = afe_colour_e'(setup4[`AFE_COLOUR_POS +: 2]);
  assign adc_range_select = setup1[`AFE_RANGE_POS +: 2];
  assign output_invert = setup2[`AFE_INVERT_POS];
  assign output_latency = setup2[`AFE_LATENCY_POS +: 2];

  always_comb begin
    case (colour_select)
      AFE_GREEN: begin
        sel_offset = offset_code_green;
        sel_gain = gain_code_green;
      end
      AFE_BLUE: begin
        sel_offset = offset_code_blue;
        sel_gain = gain_code_blue;
      end
      default: begin
        sel_offset = offset_code_red;
        sel_gain = gain_code_red;
      end
    endcase
    v2 = 32'(sample_diff) + ((32'(sel_offset) - `AFE_OFFSET_MID)
         <<< `AFE_OFFSET_SHIFT);
    v3 = (v2 * (`AFE_GAIN_UNITY + $signed(32'(sel_gain))))
         >>> `AFE_GAIN_SHIFT;
    case (adc_range_select)
      2'b10: d1 = v3 + `AFE_CODE_MAX;
      2'b11: d1 = v3;
      default: d1 = v3 + `AFE_CODE_MID;
    endcase
    if (d1 < 0) begin
      next_code = 16'h0000;
    end else if (d1 > `AFE_CODE_MAX) begin
      next_code = 16'hFFFF;
    end else begin
      next_code = d1[15:0];
    end
    if (output_invert) begin
      next_code = 16'hFFFF - next_code;
    end
  end

  logic [15:0] stage [0:PIPE_DEPTH];
  assign stage[0] = next_code;

  generate
    for (genvar i = 1; i <= PIPE_DEPTH; i++) begin : g_pipe
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          stage[i] <= 16'h0000;
        end else if (sample_sync_pulse_rise) begin
          stage[i] <= stage[i-1];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Nibble output
  // ****************************************************************
  logic [15:0] out_word;
  logic [1:0] nib_idx;
  logic [2:0] hold_cnt;
  logic nib_busy, nib_load;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_word <= 16'h0000;
      last_code <= 16'h0000;
    end else if (sample_sync_pulse_rise) begin
      out_word <= stage[output_latency];
      last_code <= next_code;
    end
  end

  assign nib_load = clk_en && nib_busy &&
                    hold_cnt == 3'(`AFE_NIBBLE_HOLD_CYC - 1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nib_busy <= 1'b0;
      nib_idx <= 2'h0;
      hold_cnt <= 3'h0;
    end else if (sample_sync_pulse_rise) begin
      nib_busy <= 1'b1;
      nib_idx <= 2'h0;
      hold_cnt <= 3'(`AFE_NIBBLE_HOLD_CYC - 1);
    end else if (nib_load) begin
      hold_cnt <= 3'h0;
      nib_idx <= nib_idx + 2'h1;
      if (nib_idx == 2'h3) begin
        nib_busy <= 1'b0;
      end
    end else if (clk_en && nib_busy) begin
      hold_cnt <= hold_cnt + 3'h1;
    end
  end

  logic [3:0] nib_data;
  logic nib_step;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nib_data <= 4'h0;
      nib_step <= 1'b0;
    end else if (nib_load) begin
      nib_data <= out_word[4'(15 - 4 * nib_idx) -: 4];
      nib_step <= !nib_step;
    end
  end

  // The step flag leaves through the same register stage as the bus, so
  // the far end never sees a step before the nibble that it announces.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link.nibble_out_bus <= 4'h0;
      link.nibble_step_toggle <= 1'b0;
    end else if (clk_en) begin
      link.nibble_step_toggle <= nib_step;
      link.nibble_out_bus <= {rd_active ? rd_shift[7] : nib_data[3],
                              nib_data[2:0]};
    end
  end
endmodule
`default_nettype wire

// ### rtl/afe_host.sv
// Controller end: drives the serial pins and sample sync, takes nibbles.
// Assumes software on the command port; the front end on the link.
`timescale 1ns/1ns
`default_nettype none
module afe_host import afe_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  afe_if.host link,
  input wire logic [1:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  input wire logic sample_req,
  output logic [15:0] sample_word,
  output logic sample_valid
);
  localparam logic [3:0] HALF = 4'(`AFE_SCK_HALF_CYC);

  // ****************************************************************
  // Frame engine
  // ****************************************************************
  afe_host_state_e state;
  logic [3:0] half_cnt, bit_cnt;
  logic [`AFE_FRAME_BITS-1:0] tx_shift;
  logic [7:0] rx_shift, read_data;
  logic is_read, boot_reset, half_end, start;
  logic [4:0] rx_pins;

  afe_sync #(.WIDTH(5)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({link.nibble_step_toggle, link.nibble_out_bus}),
    .sync_out(rx_pins)
  );

  assign half_end = half_cnt == HALF - 4'h1;
  // Frames go out in the order written; a frame write is taken only in
  // AFE_H_IDLE, and one written while a frame is in flight is dropped.
  assign start = state == AFE_H_IDLE &&
                 ((cmd_wr && cmd_addr == `AFE_HREG_FRAME) || boot_reset);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= AFE_H_IDLE;
      half_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      tx_shift <= '0;
      rx_shift <= 8'h00;
      read_data <= 8'h00;
      is_read <= 1'b0;
      boot_reset <= 1'b1;
      link.sck <= 1'b0;
      link.sdi <= 1'b0;
      link.serial_enable_strobe <= 1'b0;
    end else if (clk_en) begin
      half_cnt <= half_end ? 4'h0 : half_cnt + 4'h1;
      case (state)
        AFE_H_IDLE: begin
          half_cnt <= 4'h0;
          if (start) begin
            // First frame after reset is a software reset.
            tx_shift <= boot_reset ? {`AFE_ADDR_SWRST, 8'h00}
                                   : cmd_wdata[`AFE_FRAME_BITS-1:0];
            link.sdi <= boot_reset ? 1'b0 : cmd_wdata[13];
            is_read <= !boot_reset && cmd_wdata[8 + `AFE_READ_BIT];
            boot_reset <= 1'b0;
            bit_cnt <= 4'h0;
            state <= AFE_H_SHIFT;
          end
        end
        AFE_H_SHIFT: begin
          if (half_end) begin
            link.sck <= !link.sck;
            if (link.sck) begin
              tx_shift <= {tx_shift[`AFE_FRAME_BITS-2:0], 1'b0};
              link.sdi <= tx_shift[`AFE_FRAME_BITS-2];
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(`AFE_FRAME_BITS - 1)) begin
                link.sdi <= 1'b0;
                link.serial_enable_strobe <= 1'b1;
                state <= AFE_H_STROBE;
              end
            end
          end
        end
        AFE_H_STROBE: begin
          if (half_end) begin
            link.serial_enable_strobe <= 1'b0;
            state <= AFE_H_GAP;
          end
        end
        AFE_H_GAP: begin
          if (half_end) begin
            bit_cnt <= 4'h0;
            state <= is_read ? AFE_H_READ : AFE_H_IDLE;
          end
        end
        AFE_H_READ: begin
          // Sample late in the high phase to cover both synchronisers.
          if (half_end && link.sck) begin
            rx_shift <= {rx_shift[6:0], rx_pins[3]};
          end
          if (half_end) begin
            link.sck <= !link.sck;
            if (link.sck) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(`AFE_WORD_BITS - 1)) begin
                read_data <= {rx_shift[6:0], rx_pins[3]};
                state <= AFE_H_IDLE;
              end
            end
          end
        end
        default: state <= AFE_H_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Sample sync and nibble assembly
  // ****************************************************************
  logic [2:0] sample_sync_pulse_cnt;
  logic toggle_q;
  logic [1:0] nib_cnt;
  logic [11:0] acc;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sample_sync_pulse_cnt <= 3'h0;
      link.sample_sync_pulse <= 1'b0;
    end else if (clk_en) begin
      if (sample_req && sample_sync_pulse_cnt == 3'h0) begin
        sample_sync_pulse_cnt <= 3'(`AFE_SAMPLE_SYNC_PULSE_WIDTH_CYC);
        link.sample_sync_pulse <= 1'b1;
      end else if (sample_sync_pulse_cnt != 3'h0) begin
        sample_sync_pulse_cnt <= sample_sync_pulse_cnt - 3'h1;
        link.sample_sync_pulse <= sample_sync_pulse_cnt != 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      toggle_q <= 1'b0;
      nib_cnt <= 2'h0;
      acc <= 12'h000;
      sample_word <= 16'h0000;
      sample_valid <= 1'b0;
    end else if (clk_en) begin
      toggle_q <= rx_pins[4];
      sample_valid <= 1'b0;
      if (rx_pins[4] != toggle_q) begin
        acc <= {acc[7:0], rx_pins[3:0]};
        nib_cnt <= nib_cnt + 2'h1;
        if (nib_cnt == 2'h3) begin
          sample_word <= {acc, rx_pins[3:0]};
          sample_valid <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Command port read data
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_rdata <= 16'h0000;
    end else if (clk_en) begin
      cmd_rdata <= 16'h0000;
      if (cmd_rd) begin
        if (cmd_addr == `AFE_HREG_STATUS) begin
          cmd_rdata <= {15'h0000, state != AFE_H_IDLE || boot_reset};
        end else if (cmd_addr == `AFE_HREG_READ) begin
          cmd_rdata <= {8'h00, read_data};
        end else if (cmd_addr == `AFE_HREG_SAMPLE) begin
          cmd_rdata <= sample_word;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/afe_if.sv
// Pins between the front end and its controller.
// Assumes the bench instantiates it once and joins both ends to it.
`timescale 1ns/1ns
`default_nettype none
interface afe_if;
  logic sck;
  logic sdi;
  logic serial_enable_strobe;
  logic sample_sync_pulse;
  logic [3:0] nibble_out_bus;
  logic nibble_step_toggle;
  modport device (
    input sck,
    input sdi,
    input serial_enable_strobe,
    input sample_sync_pulse,
    output nibble_out_bus,
    output nibble_step_toggle
  );
  modport host (
    output sck,
    output sdi,
    output serial_enable_strobe,
    output sample_sync_pulse,
    input nibble_out_bus,
    input nibble_step_toggle
  );
endinterface
`default_nettype wire

// ### rtl/afe_params.svh
// Constants for the imaging front end serial control and output path.
// Assumes inclusion by bare name from the package; the modules use its macros.
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

`define AFE_ADDR_SETUP1 6'h01
`define AFE_ADDR_SETUP2 6'h02
`define AFE_ADDR_SETUP3 6'h03
`define AFE_ADDR_SWRST 6'h04
`define AFE_ADDR_SETUP4 6'h06
`define AFE_ADDR_REVISION 6'h07
`define AFE_ADDR_SETUP5 6'h08
`define AFE_ADDR_OFF_RED 6'h20
`define AFE_ADDR_OFF_GREEN 6'h21
`define AFE_ADDR_OFF_BLUE 6'h22
`define AFE_ADDR_OFF_ALL 6'h23
`define AFE_ADDR_GAIN_RED 6'h28
`define AFE_ADDR_GAIN_GREEN 6'h29
`define AFE_ADDR_GAIN_BLUE 6'h2A
`define AFE_ADDR_GAIN_ALL 6'h2B
`define AFE_READ_BIT 4

`define AFE_DEF_SETUP1 8'h0F
`define AFE_DEF_SETUP2 8'h23
`define AFE_DEF_SETUP3 8'h1F
`define AFE_DEF_SETUP4 8'h05
`define AFE_DEF_SETUP5 8'h00
`define AFE_DEF_OFFSET 8'h80
`define AFE_DEF_GAIN 8'h00

`define AFE_RANGE_POS 4
`define AFE_INVERT_POS 2
`define AFE_LATENCY_POS 6
`define AFE_COLOUR_POS 4

`define AFE_CODE_MAX 32'sd65535
`define AFE_CODE_MID 32'sd32767
`define AFE_OFFSET_MID 32'sd128
`define AFE_OFFSET_SHIFT 4
`define AFE_GAIN_UNITY 32'sd32
`define AFE_GAIN_SHIFT 5

`define AFE_CLK_PERIOD_NS 100
`define AFE_SCK_PERIOD_NS 1600
`define AFE_SCK_HALF_CYC (`AFE_SCK_PERIOD_NS / (2 * `AFE_CLK_PERIOD_NS))
`define AFE_NIBBLE_HOLD_CYC 4
`define AFE_SAMPLE_SYNC_PULSE_WIDTH_CYC 4
`define AFE_FRAME_BITS 14
`define AFE_WORD_BITS 8

`define AFE_HREG_FRAME 2'h0
`define AFE_HREG_STATUS 2'h1
`define AFE_HREG_READ 2'h2
`define AFE_HREG_SAMPLE 2'h3

`endif

// ### rtl/afe_pkg.sv
// Types shared by both ends of the front end serial link.
// Assumes afe_params.svh is on the include path.
`include "afe_params.svh"
package afe_pkg;
  typedef enum logic [1:0] {
    AFE_RED, AFE_GREEN, AFE_BLUE, AFE_RESERVED
  } afe_colour_e;
  typedef enum logic [2:0] {
    AFE_H_IDLE, AFE_H_SHIFT, AFE_H_STROBE, AFE_H_GAP, AFE_H_READ
  } afe_host_state_e;
endpackage

// ### rtl/afe_sync.sv
// Two flip-flop synchroniser for a group of unrelated levels.
// Assumes each bit is a level that is read only after the second stage.
`timescale 1ns/1ns
`default_nettype none
module afe_sync import afe_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### tb/afe_link_sva.sv
// Checker for the serial link and nibble stream pins.
// Assumes the bench feeds it the signals of the shared interface.
`timescale 1ns/1ns
`default_nettype none
module afe_link_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic sdi,
  input wire logic serial_enable_strobe,
  input wire logic sample_sync_pulse,
  input wire logic [3:0] nibble_out_bus,
  input wire logic nibble_step_toggle
);
  // ****
  // Link timing
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_SDI_HOLD: assert property (
    sck && $past(sck) |-> $stable(sdi)) else $error("sdi moved in sck high");
  AST_SCK_HIGH: assert property (
    $rose(sck) |-> sck [*8] ##1 !sck) else $error("sck high phase wrong");
  AST_SCK_LOW: assert property (
    $fell(sck) |-> (!sck) [*8]) else $error("sck low phase too short");
  AST_SEN_IDLE: assert property (
    serial_enable_strobe |-> !sck) else $error("enable with sck high");
  AST_SEN_WIDTH: assert property (
    $rose(serial_enable_strobe) |-> serial_enable_strobe [*8] ##1
    !serial_enable_strobe) else $error("enable pulse width wrong");
  AST_SYNC_WIDTH: assert property (
    $rose(sample_sync_pulse) |-> sample_sync_pulse [*4] ##1
    !sample_sync_pulse) else $error("sync pulse width wrong");
  AST_NIB_HOLD: assert property (
    $changed(nibble_step_toggle) |=> $stable(nibble_step_toggle) [*3])
    else $error("nibble held under four cycles");
  AST_NIB_STEP: assert property (
    $changed(nibble_out_bus[2:0]) |-> $changed(nibble_step_toggle) ||
    $past(nibble_step_toggle) != $past(nibble_step_toggle, 2))
    else $error("nibble moved without a step");
endmodule
`default_nettype wire

// ### tb/afe_serial_control_output_path_bench.sv
// Bench joining both ends; software orders go through the command port.
// Assumes the design files and afe_link_sva are compiled first.
`timescale 1ns/1ns
`default_nettype none
module afe_serial_control_output_path_bench import afe_pkg::*;;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] cmd_addr = 2'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic sample_req = 1'b0;
  logic signed [15:0] sample_diff = 16'sh0000;
  logic [15:0] cmd_rdata, sample_word, last_code, rv;
  logic sample_valid;
  int err_count = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int of[4] = '{144, 112, 128, 144};
  int gn[4] = '{0, 0, 32, 0};
  int rg[6] = '{0, 1, 2, 3, 2, 3};
  int dv[6] = '{5, 0, 0, 0, 700, -700};
  afe_if lnk ();
  afe_device i_afe_device (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .link(lnk), .sample_diff(sample_diff),
    .last_code(last_code));
  afe_host i_afe_host (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .link(lnk), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .sample_req(sample_req), .sample_word(sample_word),
    .sample_valid(sample_valid));
  afe_link_sva i_sva (.core_clk(core_clk), .sys_rst(sys_rst),
    .sck(lnk.sck), .sdi(lnk.sdi),
    .serial_enable_strobe(lnk.serial_enable_strobe),
    .sample_sync_pulse(lnk.sample_sync_pulse),
    .nibble_out_bus(lnk.nibble_out_bus),
    .nibble_step_toggle(lnk.nibble_step_toggle));
  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge core_clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge core_clk);
    cmd_rd <= 1'b0;
    #1;
    d = cmd_rdata;
  endtask
  // Polls the busy flag so that no frame write is dropped.
  task automatic idle;
    int n;
    n = 0;
    repeat (2) @(posedge core_clk);
    rd(2'h1, rv);
    while (rv[0] !== 1'b0 && n < 2000) begin
      rd(2'h1, rv);
      n++;
    end
  endtask
  task automatic frame(input logic [5:0] a, input logic [7:0] d);
    idle();
    wr(2'h0, {2'h0, a, d});
    idle();
  endtask
  task automatic rdback(input logic [5:0] a, input logic [7:0] e);
    frame(a | 6'h10, 8'h00);
    rd(2'h2, rv);
    chk(rv, {8'h00, e});
  endtask
  task automatic smp(input int d, output logic [15:0] w);
    int n;
    n = 0;
    @(posedge core_clk);
    sample_diff <= d[15:0];
    sample_req <= 1'b1;
    @(posedge core_clk);
    sample_req <= 1'b0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (sample_valid !== 1'b1 && n < 200);
    w = sample_word;
    repeat (8) @(posedge core_clk);
  endtask
  function automatic logic [15:0] code(int d, int o, int g, int r, bit i);
    int v;
    v = ((d + (o - 128) * 16) * (32 + g)) >>> 5;
    v = v + (r == 2 ? 65535 : (r == 3 ? 0 : 32767));
    v = v < 0 ? 0 : (v > 65535 ? 65535 : v);
    return i ? 16'(65535 - v) : 16'(v);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****
  // Clock, timeout and tests
  // ****
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdback(6'h01, 8'h0F);
    rdback(6'h02, 8'h23);
    rdback(6'h07, 8'h5A);
    frame(6'h20, 8'h90);
    frame(6'h21, 8'h70);
    frame(6'h2A, 8'h20);
    rdback(6'h2A, 8'h20);
    rdback(6'h21, 8'h70);
    $display("test done: registers");
    for (int c = 0; c < 4; c++) begin
      frame(6'h06, 8'(8'h05 | (c << 4)));
      smp(10, rv);
      chk(rv, code(10, of[c], gn[c], 0, 0));
    end
    $display("test done: colours");
    frame(6'h04, 8'hA5);
    rdback(6'h20, 8'h80);
    rdback(6'h2A, 8'h00);
    $display("test done: soft reset");
    for (int i = 0; i < 6; i++) begin
      frame(6'h01, 8'(8'h0F | (rg[i] << 4)));
      smp(dv[i], rv);
      chk(rv, code(dv[i], 128, 0, rg[i], 0));
    end
    frame(6'h02, 8'h27);
    smp(300, rv);
    chk(rv, code(300, 128, 0, 3, 1));
    frame(6'h02, 8'h63);
    smp(40, rv);
    smp(90, rv);
    chk(rv, code(40, 128, 0, 3, 0));
    chk(last_code, code(90, 128, 0, 3, 0));
    $display("test done: sample path");
    tally_and_finish();
  end
endmodule
`default_nettype wire
